// ---- core/baud_regs.svh ----
// Register indices, field positions, reset values and ratios of the rate generator
`ifndef BAUD_REGS_SVH
`define BAUD_REGS_SVH
`define RX_CTRL_IDX 8'h18
`define TX_CTRL_IDX 8'h98
`define DIV_IDX 8'h99
`define STATUS_IDX 8'h9a
`define TX_CLOCK_SOURCE_SELECT_BIT 7
`define TX_SYNC_BIT 4
`define TX_HS_BIT 2
`define TX_SHIFT_EMPTY_BIT 1
`define RX_SERIAL_PORT_ENABLE_BIT 7
`define TX_WR_MASK 8'hf5
`define RX_WR_MASK 8'hf0
`define TX_CTRL_RST 8'h02
`define RX_CTRL_RST 8'h00
`define DIV_RST 8'h00
`define RATIO_SLOW 7'd64
`define RATIO_FAST 7'd16
`define RATIO_SYNC 7'd4
`endif

// ---- core/baud_pkg.sv ----
// Types shared by the rate generator and its neighbours
package baud_pkg;
  typedef struct packed {
    logic port_enable;
    logic sync_mode;
    logic master_clock;
    logic high_speed;
  } mode_s;
  typedef struct packed {
    logic rate_tick;
    logic bit_tick;
    logic rx_level;
  } tick_s;
endpackage : baud_pkg

// ---- core/serial_baud_rate_generator.sv ----
// Serial port rate generator with receive pin majority detector and Wishbone registers
// Behaviour
// - One dedicated 8-bit generator serves both asynchronous and synchronous modes.
// - The generator is a free-running 8-bit timer with period from the divisor.
// - In asynchronous mode the high-speed bit also sets the bit rate.
// - In synchronous mode the high-speed bit is ignored.
// - Async, low speed: bit rate is clock over 64 times divisor plus one.
// - Async, high speed: bit rate is clock over 16 times divisor plus one.
// - Sync mode: bit rate is clock over 4 times divisor plus one.
// - In sync mode, divisor rates apply only as master with internal clock; slave gets none.
// - Every divisor value from 0 to 255 is accepted and legal.
// - Writing the divisor loads it into the timer and clears the prescale so the new rate starts at once.
// - Receive pin is sampled three times and decided by majority.
// - Asynchronous operation is selected by clearing the sync mode bit.
// - In asynchronous mode the timer runs at 16 or 64 times bit rate.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`include "baud_regs.svh"
module serial_baud_rate_generator
  import baud_pkg::*;
#(
  parameter int unsigned ADR_W = 10
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_pin_i,
  input wire logic tsr_empty_i,
  output mode_s mode_o,
  output tick_s ticks_o,
  output logic [7:0] tx_ctrl_o,
  output logic [7:0] rx_ctrl_o
);

  // Bus slave
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] idx;
  logic req, wr, wr_tx, wr_rx, wr_div;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, div_q, div_d;

  // Timer and prescale
  logic [7:0] count_q, count_d;
  logic [5:0] pre_q, pre_d;
  logic [5:0] ratio_m1;
  logic gen_active, rate_tick, bit_tick;

  // Pin synchroniser and majority detector
  logic [2:0] pin_sync_q, pin_sync_d;
  logic pin_level_q, pin_level_d;
  logic [2:0] samples_q, samples_d;
  logic rx_level_q, rx_level_d;

  assign idx = adr_i[ADR_W-1:2];
  assign req = cyc_i & stb_i & ~ack_q;
  // Write lands on the edge where the master sees ack
  assign wr = cyc_i & stb_i & we_i & ack_q & sel_i[0];
  assign wr_tx = wr & (idx == `TX_CTRL_IDX);
  assign wr_rx = wr & (idx == `RX_CTRL_IDX);
  assign wr_div = wr & (idx == `DIV_IDX);

  always_comb
  begin
    ack_d = req;
    rdat_d = 32'h0000_0000;
    tx_d = tx_q;
    rx_d = rx_q;
    div_d = div_q;
    if (req & ~we_i)
    begin
      unique case (idx)
        `TX_CTRL_IDX: rdat_d = {24'h00_0000, tx_q[7:2], tsr_empty_i, tx_q[0]};
        `RX_CTRL_IDX: rdat_d = {24'h00_0000, rx_q};
        `DIV_IDX: rdat_d = {24'h00_0000, div_q};
        `STATUS_IDX: rdat_d = {30'h0000_0000, gen_active, rx_level_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    if (wr_tx)
      tx_d = dat_i[7:0] & `TX_WR_MASK;
    if (wr_rx)
      rx_d = dat_i[7:0] & `RX_WR_MASK;
    if (wr_div)
      div_d = dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      tx_q <= `TX_CTRL_RST & `TX_WR_MASK;
      rx_q <= `RX_CTRL_RST;
      div_q <= `DIV_RST;
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      div_q <= div_d;
    end
  end

  // Slave mode takes its clock from the pin, so the timer is held
  assign gen_active = rx_q[`RX_SERIAL_PORT_ENABLE_BIT] & (~tx_q[`TX_SYNC_BIT] | tx_q[`TX_CLOCK_SOURCE_SELECT_BIT]);

  always_comb
  begin
    if (tx_q[`TX_SYNC_BIT])
      ratio_m1 = 6'(`RATIO_SYNC - 7'd1);
    else if (tx_q[`TX_HS_BIT])
      ratio_m1 = 6'(`RATIO_FAST - 7'd1);
    else
      ratio_m1 = 6'(`RATIO_SLOW - 7'd1);
  end

  assign rate_tick = gen_active & (count_q == 8'h00);
  // Compare, not equality: a mode change may leave pre_q above the new ratio
  assign bit_tick = rate_tick & (pre_q >= ratio_m1);

  always_comb
  begin
    count_d = count_q;
    pre_d = pre_q;
    if (wr_div)
    begin
      count_d = dat_i[7:0];
      pre_d = 6'h00;
    end
    else if (!gen_active)
    begin
      count_d = div_q;
      pre_d = 6'h00;
    end
    else if (rate_tick)
    begin
      count_d = div_q;
      pre_d = (pre_q >= ratio_m1) ? 6'h00 : 6'(pre_q + 6'h01);
    end
    else
      count_d = 8'(count_q - 8'h01);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= 8'h00;
      pre_q <= 6'h00;
    end
    else
    begin
      count_q <= count_d;
      pre_q <= pre_d;
    end
  end

  // Second and third stage must agree before the level moves
  always_comb
  begin
    pin_sync_d = {pin_sync_q[1:0], rx_pin_i};
    pin_level_d = pin_level_q;
    if (pin_sync_q[1] == pin_sync_q[2])
      pin_level_d = pin_sync_q[2];
    samples_d = samples_q;
    if (rate_tick)
      samples_d = {samples_q[1:0], pin_level_q};
    rx_level_d = (samples_q[0] & samples_q[1]) | (samples_q[1] & samples_q[2])
      | (samples_q[0] & samples_q[2]);
  end

  // Line idles high, so the detector starts at the idle level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_sync_q <= 3'h7;
      pin_level_q <= 1'b1;
      samples_q <= 3'h7;
      rx_level_q <= 1'b1;
    end
    else
    begin
      pin_sync_q <= pin_sync_d;
      pin_level_q <= pin_level_d;
      samples_q <= samples_d;
      rx_level_q <= rx_level_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;
  assign tx_ctrl_o = tx_q;
  assign rx_ctrl_o = rx_q;
  assign mode_o = '{port_enable: rx_q[`RX_SERIAL_PORT_ENABLE_BIT], sync_mode: tx_q[`TX_SYNC_BIT],
                    master_clock: tx_q[`TX_CLOCK_SOURCE_SELECT_BIT], high_speed: tx_q[`TX_HS_BIT]};
  assign ticks_o = '{rate_tick: rate_tick, bit_tick: bit_tick, rx_level: rx_level_q};

  // Checking helpers: cycles between bit ticks under a steady setting
  logic [15:0] gap_q;
  logic gap_ok_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
    end
    else
    begin
      gap_q <= bit_tick ? 16'h0001 : 16'(gap_q + 16'h0001);
      if (wr_tx | wr_rx | wr_div | ~gen_active)
        gap_ok_q <= 1'b0;
      else if (bit_tick)
        gap_ok_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking

  // Antecedents of the |=> checks except p_reset test reset too: its last edge must open no attempt

  property p_div_store;
    disable iff (rst_i) (!rst_i && wr_div) |=> div_q == $past(dat_i[7:0]);
  endproperty
  a_div_store: assert property (p_div_store) else $error("divisor not stored");

  property p_div_clear;
    disable iff (rst_i) (!rst_i && wr_div)
      |=> (count_q == $past(dat_i[7:0])) && (pre_q == 6'h00);
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("timer not cleared on write");

  property p_free_run;
    disable iff (rst_i) (!rst_i && gen_active && count_q != 8'h00 && !wr_div)
      |=> count_q == 8'($past(count_q) - 8'h01);
  endproperty
  a_free_run: assert property (p_free_run) else $error("timer did not count down");

  property p_reload;
    disable iff (rst_i) (!rst_i && rate_tick && !wr_div) |=> count_q == $past(div_q);
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload");

  property p_slow;
    disable iff (rst_i) (bit_tick && gap_ok_q && !tx_q[`TX_SYNC_BIT] && !tx_q[`TX_HS_BIT])
      |-> 32'(gap_q) == (32'(div_q) + 1) * 32'(`RATIO_SLOW);
  endproperty
  a_slow: assert property (p_slow) else $error("low speed period wrong");

  property p_fast;
    disable iff (rst_i) (bit_tick && gap_ok_q && !tx_q[`TX_SYNC_BIT] && tx_q[`TX_HS_BIT])
      |-> 32'(gap_q) == (32'(div_q) + 1) * 32'(`RATIO_FAST);
  endproperty
  a_fast: assert property (p_fast) else $error("high speed period wrong");

  property p_sync;
    disable iff (rst_i) (bit_tick && gap_ok_q && tx_q[`TX_SYNC_BIT])
      |-> 32'(gap_q) == (32'(div_q) + 1) * 32'(`RATIO_SYNC);
  endproperty
  a_sync: assert property (p_sync) else $error("sync period wrong");

  property p_slave;
    disable iff (rst_i) !gen_active |-> !rate_tick && !bit_tick;
  endproperty
  a_slave: assert property (p_slave) else $error("tick while not master");

  property p_held;
    disable iff (rst_i) (!rst_i && !gen_active && !wr_div)
      |=> (count_q == $past(div_q)) && (pre_q == 6'h00);
  endproperty
  a_held: assert property (p_held) else $error("timer not held while idle");

  property p_async_ratio;
    disable iff (rst_i) (bit_tick && gap_ok_q && !tx_q[`TX_SYNC_BIT])
      |-> 32'(gap_q) != (32'(div_q) + 1) * 32'(`RATIO_SYNC);
  endproperty
  a_async_ratio: assert property (p_async_ratio) else $error("async uses sync ratio");

  property p_majority;
    disable iff (rst_i) (!rst_i && $countones(samples_q) > 1) |=> rx_level_q;
  endproperty
  a_majority: assert property (p_majority) else $error("majority high missed");

  property p_minority;
    disable iff (rst_i) (!rst_i && $countones(samples_q) < 2) |=> !rx_level_q;
  endproperty
  a_minority: assert property (p_minority) else $error("majority low missed");

  property p_reset;
    rst_i |=> (div_q == 8'h00) && (count_q == 8'h00) && (pre_q == 6'h00);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : serial_baud_rate_generator

// ---- sim/serial_shift_model.sv ----
// Far-side shift logic stand-in: drives receive pin and shift-empty level
`timescale 1ns/10ps
module serial_shift_model
  import baud_pkg::*;
(
  input wire logic clk_i,
  input wire tick_s ticks_i,
  input wire logic line_i,
  input wire logic glitch_i,
  input wire logic empty_i,
  output logic rx_pin_o,
  output logic tsr_empty_o
);
  // Brief inversion that only the majority vote may hide
  assign rx_pin_o = line_i ^ glitch_i;
  // Idle shift register reports empty between frames
  assign tsr_empty_o = empty_i;
endmodule : serial_shift_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the serial rate generator
`timescale 1ns/10ps
`include "baud_regs.svh"
module tb_top;
  import baud_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, line = 1, glitch = 0, empty = 1;
  logic [3:0] sel = 4'hf, bsel = 4'hf;
  logic [9:0] adr = '0;
  logic [31:0] dat = '0, rdat, r;
  logic ack, rxp, tse;
  logic [7:0] txc, rxc, x, ctl;
  logic [7:0] mdl_div = `DIV_RST;
  logic [15:0] lf = 16'hac0c;
  mode_s mode;
  tick_s ticks;
  int n_errors = 0, compares = 0, k, p, ratio;
  serial_baud_rate_generator dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .rx_pin_i(rxp), .tsr_empty_i(tse), .mode_o(mode), .ticks_o(ticks), .tx_ctrl_o(txc),
    .rx_ctrl_o(rxc));
  serial_shift_model far (.clk_i(clk), .ticks_i(ticks), .line_i(line), .glitch_i(glitch),
    .empty_i(empty), .rx_pin_o(rxp), .tsr_empty_o(tse));
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  // Classic cycle; waits on ack, never on a fixed latency
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= bsel;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = rdat;
    if (w && bsel[0] && i == `DIV_IDX) mdl_div = d;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 20) chk("ack", 1, 0);
  endtask : wb
  // Cycles between two successive pulses of ticks bit b
  task automatic gap(input int b);
    k = 0;
    p = 0;
    do @(negedge clk); while (ticks[b] !== 1'b1 && ++k < 20000);
    do @(negedge clk); while (ticks[b] !== 1'b1 && ++p < 20000);
    p++;
  endtask : gap
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial
  begin
    #400000;
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    wb(0, `TX_CTRL_IDX, 0);
    chk("tx reset", `TX_CTRL_RST, r);
    wb(0, `DIV_IDX, 0);
    chk("div reset", `DIV_RST, r);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, r);
    bsel = 4'h0;
    wb(1, `DIV_IDX, 8'h33);
    bsel = 4'hf;
    wb(0, `DIV_IDX, 0);
    chk("div masked write", mdl_div, r);
    $display("test reset done");
    wb(1, `RX_CTRL_IDX, 8'h80);
    for (int m = 0; m < 4; m++)
    begin
      x = (m == 0) ? 8'h00 : (m == 3) ? 8'hff : {3'b000, lf[4:0]};
      lf = lfsr(lf);
      ctl = {m == 2, 2'b00, m == 2, 1'b0, m != 0, 2'b00};
      ratio = (m == 2) ? 4 : (m == 0) ? 64 : 16;
      wb(1, `TX_CTRL_IDX, ctl);
      wb(1, `DIV_IDX, 8'hff);
      repeat (3) @(posedge clk);
      wb(1, `DIV_IDX, x);
      k = 0;
      do @(negedge clk); while (ticks.rate_tick !== 1'b1 && ++k < 300);
      chk("first tick soon", x, k);
      gap(2);
      chk("rate period", x + 1, p);
      gap(1);
      chk("bit period", ratio * (x + 1), p);
      chk("mode", {1'b1, ctl[4], ctl[7], ctl[2]}, mode);
      chk("tx ctrl out", ctl, txc);
      chk("rx ctrl out", 8'h80, rxc);
      wb(0, `DIV_IDX, 0);
      chk("div readback", mdl_div, r);
      $display("test mode %0d divisor %0d done", m, x);
    end
    wb(1, `TX_CTRL_IDX, 8'h10);
    k = 0;
    repeat (600) @(negedge clk) k += (ticks.rate_tick !== 1'b0);
    chk("slave ticks", 0, k);
    wb(1, `TX_CTRL_IDX, 8'h04);
    wb(1, `DIV_IDX, 8'h02);
    line <= 0;
    repeat (40) @(posedge clk);
    // Two cycles get through the synchroniser, so only the vote can hide them
    glitch <= 1;
    repeat (2) @(posedge clk);
    glitch <= 0;
    k = 0;
    repeat (40) @(negedge clk) k += (ticks.rx_level !== 1'b0);
    chk("rx glitch hidden", 0, k);
    wb(0, `STATUS_IDX, 0);
    chk("rx low", 8'h02, r);
    line <= 1;
    empty <= 0;
    repeat (40) @(posedge clk);
    wb(0, `STATUS_IDX, 0);
    chk("rx high", 8'h03, r);
    wb(0, `TX_CTRL_IDX, 0);
    chk("tx shift busy", 8'h04, r);
    $display("test pin and status done");
    wb(1, `DIV_IDX, 8'h5a);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    wb(0, `DIV_IDX, 0);
    chk("div after reset", 0, r);
    chk("mode after reset", 0, mode);
    chk("tx after reset", 0, txc);
    $display("test second reset done");
    close_out();
  end
endmodule : tb_top
